// ### rtl/pwmol_ahb_front.sv
// AHB-Lite data phase tracker for all registers of the override and buffered load block
`timescale 1ns/1ps
module pwmol_ahb_front
   import pwmol_pkg::*;
(
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // AHB address phase
   input  wire logic              hsel,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [ADDR_W-1:0] haddr,
   input  wire logic              hready,
   // Register side
   output logic                   hreadyout,
   output logic                   wr_stb,
   output logic                   rd_stb,
   output logic [ADDR_W-1:0]      reg_addr
);

   pwmol_state_e      st_q;
   pwmol_state_e      st_d;
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] addr_d;
   logic              accept;

   // ==========================================================
   // Next state
   always_comb begin
      accept = hsel && hready && htrans[1];
      addr_d = accept ? haddr : addr_q;
      st_d   = PWMOL_ST_IDLE;
      case (st_q)
         PWMOL_ST_RWAIT: st_d = PWMOL_ST_RDONE;
         PWMOL_ST_IDLE, PWMOL_ST_WRITE, PWMOL_ST_RDONE: begin
            if (accept) begin
               st_d = hwrite ? PWMOL_ST_WRITE : PWMOL_ST_RWAIT;
            end
         end
         default: st_d = PWMOL_ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q   <= PWMOL_ST_IDLE;
         addr_q <= '0;
      end else begin
         st_q   <= st_d;
         addr_q <= addr_d;
      end
   end

   // Read data captured during the wait cycle
   assign hreadyout = (st_q != PWMOL_ST_RWAIT);
   assign wr_stb    = (st_q == PWMOL_ST_WRITE);
   assign rd_stb    = (st_q == PWMOL_ST_RWAIT);
   assign reg_addr  = addr_q;

endmodule

// ### rtl/pwmol_out_stage.sv
// Final output stage: software override ahead of the generated channel level
`timescale 1ns/1ps
module pwmol_out_stage
   import pwmol_pkg::*;
(
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // Levels in
   input  wire logic [NUM_CH-1:0] chan_gen,
   input  wire logic [NUM_CH-1:0] ovr_en,
   input  wire logic [NUM_CH-1:0] ovr_val,
   // Pins out
   output logic [NUM_CH-1:0]      chan_out
);

   logic [NUM_CH-1:0] out_q;
   logic [NUM_CH-1:0] out_d;

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         out_d[i] = ovr_en[i] ? ovr_val[i] : chan_gen[i];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_q <= RST_CH;
      end else begin
         out_q <= out_d;
      end
   end

   assign chan_out = out_q;

endmodule

// ### rtl/pwmol_pkg.sv
// Package: constants for the PWM output override and buffered load block
package pwmol_pkg;

   // ==========================================================
   // Sizes
   localparam int          NUM_CH      = 8;
   localparam int          CNT_W       = 16;
   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 32;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0]  OFF_PERIOD  = 8'h00;
   localparam logic [7:0]  OFF_START   = 8'h04;
   localparam logic [7:0]  OFF_CMP0    = 8'h08;
   localparam logic [7:0]  OFF_OVR     = 8'h28;
   localparam logic [7:0]  OFF_LOAD    = 8'h2C;
   localparam logic [7:0]  OFF_SYNC    = 8'h30;
   localparam logic [7:0]  OFF_OVR_ACT = 8'h34;
   localparam logic [7:0]  CMP_STRIDE  = 8'h04;

   // ==========================================================
   // Field positions
   localparam int          OVR_EN_LSB  = 0;
   localparam int          OVR_VAL_LSB = 8;
   localparam int          LOAD_SEL_LSB = 0;
   localparam int          LOAD_EN_BIT = 9;
   localparam int          SYNC_SEL_BIT = 5;

   // ==========================================================
   // Reset values
   localparam logic [15:0] RST_CNT     = 16'h0000;
   localparam logic [7:0]  RST_CH      = 8'h00;
   localparam logic [31:0] RST_WORD    = 32'h0000_0000;

   // ==========================================================
   // AHB encodings
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic        HRESP_OKAY  = 1'b0;

   // Data phase states, one-hot
   typedef enum logic [3:0] {
      PWMOL_ST_IDLE  = 4'h1,
      PWMOL_ST_WRITE = 4'h2,
      PWMOL_ST_RWAIT = 4'h4,
      PWMOL_ST_RDONE = 4'h8
   } pwmol_state_e;

endpackage

// ### rtl/pwmol_top.sv
// Top: software output override and buffered period/start/compare load
//
// Overview of operation
// - Per-channel override enable bit decides whether software takes over the output.
// - Enabled override with value bit 0 drives the channel low.
// - Enabled override with value bit 1 drives the channel high while enabled.
// - Buffered period, start and compare values copy to active on wrap or match.
// - Channel match is counter equal to that channel's active compare value.
// - Loading happens only while the load enable bit is set.
// - A channel match counts as load point only when its select bit is set.
// - Load register bits 31..10 and 8 read zero and ignore writes.
// - Override register writes are buffered, applied only by its sync event.
// - Sync select bit 0 applies buffer every clock, 1 only on PWM sync.
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module pwmol_top
   import pwmol_pkg::*;
(
   // Clock and reset
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   // AHB-Lite slave
   input  wire logic                        hsel,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [ADDR_W-1:0]           haddr,
   input  wire logic [DATA_W-1:0]           hwdata,
   input  wire logic                        hready,
   output logic                             hreadyout,
   output logic                             hresp,
   output logic [DATA_W-1:0]                hrdata,
   // Counter and sync events
   input  wire logic [CNT_W-1:0]            cnt_value,
   input  wire logic                        cnt_wrap,
   input  wire logic                        pwm_sync,
   // Channel levels
   input  wire logic [NUM_CH-1:0]           chan_gen,
   output logic [NUM_CH-1:0]                chan_out,
   // Active values
   output logic [CNT_W-1:0]                 period_limit,
   output logic [CNT_W-1:0]                 counter_start_value,
   output logic [NUM_CH-1:0][CNT_W-1:0]     cmp_active,
   output logic                             load_done
);

   // ==========================================================
   // Helper functions

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   function automatic logic [DATA_W-1:0] zext_cnt(input logic [CNT_W-1:0] v);
      zext_cnt = {{(DATA_W-CNT_W){1'b0}}, v};
   endfunction

   // ==========================================================
   // Bus front end

   logic              wr_stb;
   logic              rd_stb;
   logic [ADDR_W-1:0] reg_addr;

   pwmol_ahb_front u_front (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .haddr     (haddr),
      .hready    (hready),
      .hreadyout (),
      .wr_stb    (wr_stb),
      .rd_stb    (rd_stb),
      .reg_addr  (reg_addr)
   );

   // ==========================================================
   // Software registers: buffers and control

   logic [CNT_W-1:0]              per_buf_q;
   logic [CNT_W-1:0]              per_buf_d;
   logic [CNT_W-1:0]              start_buf_q;
   logic [CNT_W-1:0]              start_buf_d;
   logic [NUM_CH-1:0][CNT_W-1:0]  cmp_buf_q;
   logic [NUM_CH-1:0][CNT_W-1:0]  cmp_buf_d;
   logic [NUM_CH-1:0]             ovr_en_buf_q;
   logic [NUM_CH-1:0]             ovr_en_buf_d;
   logic [NUM_CH-1:0]             ovr_val_buf_q;
   logic [NUM_CH-1:0]             ovr_val_buf_d;
   logic [NUM_CH-1:0]             sel_q;
   logic [NUM_CH-1:0]             sel_d;
   logic                          load_en_q;
   logic                          load_en_d;
   logic                          sync_sel_q;
   logic                          sync_sel_d;

   always_comb begin
      per_buf_d     = per_buf_q;
      start_buf_d   = start_buf_q;
      cmp_buf_d     = cmp_buf_q;
      ovr_en_buf_d  = ovr_en_buf_q;
      ovr_val_buf_d = ovr_val_buf_q;
      sel_d         = sel_q;
      load_en_d     = load_en_q;
      sync_sel_d    = sync_sel_q;
      if (wr_stb) begin
         if (hit(reg_addr, OFF_PERIOD)) begin
            per_buf_d = hwdata[CNT_W-1:0];
         end
         if (hit(reg_addr, OFF_START)) begin
            start_buf_d = hwdata[CNT_W-1:0];
         end
         for (int i = 0; i < NUM_CH; i++) begin
            if (hit(reg_addr, OFF_CMP0 + CMP_STRIDE * 8'(i))) begin
               cmp_buf_d[i] = hwdata[CNT_W-1:0];
            end
         end
         if (hit(reg_addr, OFF_OVR)) begin
            // Only the buffer takes the write
            ovr_en_buf_d  = hwdata[OVR_EN_LSB +: NUM_CH];
            ovr_val_buf_d = hwdata[OVR_VAL_LSB +: NUM_CH];
         end
         if (hit(reg_addr, OFF_LOAD)) begin
            // Bits 8 and 31..10 are not stored
            sel_d     = hwdata[LOAD_SEL_LSB +: NUM_CH];
            load_en_d = hwdata[LOAD_EN_BIT];
         end
         if (hit(reg_addr, OFF_SYNC)) begin
            sync_sel_d = hwdata[SYNC_SEL_BIT];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         per_buf_q     <= RST_CNT;
         start_buf_q   <= RST_CNT;
         cmp_buf_q     <= '0;
         ovr_en_buf_q  <= RST_CH;
         ovr_val_buf_q <= RST_CH;
         sel_q         <= RST_CH;
         load_en_q     <= 1'b0;
         sync_sel_q    <= 1'b0;
      end else begin
         per_buf_q     <= per_buf_d;
         start_buf_q   <= start_buf_d;
         cmp_buf_q     <= cmp_buf_d;
         ovr_en_buf_q  <= ovr_en_buf_d;
         ovr_val_buf_q <= ovr_val_buf_d;
         sel_q         <= sel_d;
         load_en_q     <= load_en_d;
         sync_sel_q    <= sync_sel_d;
      end
   end

   // ==========================================================
   // Active override bits

   logic [NUM_CH-1:0] ovr_en_q;
   logic [NUM_CH-1:0] ovr_en_d;
   logic [NUM_CH-1:0] ovr_val_q;
   logic [NUM_CH-1:0] ovr_val_d;
   logic              ovr_xfer;

   always_comb begin
      ovr_xfer  = !sync_sel_q || pwm_sync;
      ovr_en_d  = ovr_xfer ? ovr_en_buf_q : ovr_en_q;
      ovr_val_d = ovr_xfer ? ovr_val_buf_q : ovr_val_q;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ovr_en_q  <= RST_CH;
         ovr_val_q <= RST_CH;
      end else begin
         ovr_en_q  <= ovr_en_d;
         ovr_val_q <= ovr_val_d;
      end
   end

   pwmol_out_stage u_out (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .chan_gen (chan_gen),
      .ovr_en   (ovr_en_q),
      .ovr_val  (ovr_val_q),
      .chan_out (chan_out)
   );

   // ==========================================================
   // Match detection and buffered load

   logic [CNT_W-1:0]             per_act_q;
   logic [CNT_W-1:0]             per_act_d;
   logic [CNT_W-1:0]             start_act_q;
   logic [CNT_W-1:0]             start_act_d;
   logic [NUM_CH-1:0][CNT_W-1:0] cmp_act_q;
   logic [NUM_CH-1:0][CNT_W-1:0] cmp_act_d;
   logic [NUM_CH-1:0]            match;
   logic                         load_point;
   logic                         load_fire;
   logic                         load_done_q;
   logic                         load_done_d;

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         match[i] = (cnt_value == cmp_act_q[i]);
      end
      load_point  = cnt_wrap || |(match & sel_q);
      load_fire   = load_point && load_en_q;
      per_act_d   = load_fire ? per_buf_q : per_act_q;
      start_act_d = load_fire ? start_buf_q : start_act_q;
      cmp_act_d   = load_fire ? cmp_buf_q : cmp_act_q;
      load_done_d = load_fire;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         per_act_q   <= RST_CNT;
         start_act_q <= RST_CNT;
         cmp_act_q   <= '0;
         load_done_q <= 1'b0;
      end else begin
         per_act_q   <= per_act_d;
         start_act_q <= start_act_d;
         cmp_act_q   <= cmp_act_d;
         load_done_q <= load_done_d;
      end
   end

   // ==========================================================
   // Read path and bus answer

   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [DATA_W-1:0] rmux;
   logic              ready_q;
   logic              ready_d;

   always_comb begin
      rmux = RST_WORD;
      if (hit(reg_addr, OFF_PERIOD)) begin
         rmux = zext_cnt(per_buf_q);
      end
      if (hit(reg_addr, OFF_START)) begin
         rmux = zext_cnt(start_buf_q);
      end
      for (int i = 0; i < NUM_CH; i++) begin
         if (hit(reg_addr, OFF_CMP0 + CMP_STRIDE * 8'(i))) begin
            rmux = zext_cnt(cmp_buf_q[i]);
         end
      end
      if (hit(reg_addr, OFF_OVR)) begin
         rmux[OVR_EN_LSB +: NUM_CH]  = ovr_en_buf_q;
         rmux[OVR_VAL_LSB +: NUM_CH] = ovr_val_buf_q;
      end
      if (hit(reg_addr, OFF_LOAD)) begin
         rmux[LOAD_SEL_LSB +: NUM_CH] = sel_q;
         rmux[LOAD_EN_BIT]            = load_en_q;
      end
      if (hit(reg_addr, OFF_SYNC)) begin
         rmux[SYNC_SEL_BIT] = sync_sel_q;
      end
      if (hit(reg_addr, OFF_OVR_ACT)) begin
         rmux[OVR_EN_LSB +: NUM_CH]  = ovr_en_q;
         rmux[OVR_VAL_LSB +: NUM_CH] = ovr_val_q;
      end
      rdata_d = rd_stb ? rmux : rdata_q;
      // Mirrors the front end so hreadyout comes from a flop here
      ready_d = !(hsel && hready && htrans[1] && !hwrite);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= RST_WORD;
         ready_q <= 1'b1;
      end else begin
         rdata_q <= rdata_d;
         ready_q <= ready_d;
      end
   end

   assign hrdata              = rdata_q;
   assign hreadyout           = ready_q;
   assign hresp               = HRESP_OKAY;
   assign period_limit        = per_act_q;
   assign counter_start_value = start_act_q;
   assign cmp_active          = cmp_act_q;
   assign load_done           = load_done_q;

endmodule

// ### tb/pwmol_cnt_model.sv
// Counter model driving the count value and wrap pulse of the block
`timescale 1ns/1ps
module pwmol_cnt_model
   import pwmol_pkg::*;
(
   // Clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // Control
   input  wire logic             run,
   input  wire logic [CNT_W-1:0] period_limit,
   input  wire logic [CNT_W-1:0] counter_start_value,
   // Count out
   output logic [CNT_W-1:0]      cnt_value,
   output logic                  cnt_wrap
);
   // ==========================================
   // Up counter, holds while stopped
   assign cnt_wrap = run && (cnt_value == period_limit);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_value <= RST_CNT;
      end else if (cnt_wrap) begin
         cnt_value <= counter_start_value;
      end else if (run) begin
         cnt_value <= cnt_value + 16'h0001;
      end
   end
endmodule

// ### tb/pwmol_top_assertions.sv
// Port checks for the override and buffered load block
`timescale 1ns/1ps
module pwmol_chk
   import pwmol_pkg::*;
(
   // Clock and reset
   input wire logic                    hclk,
   input wire logic                    hresetn,
   // Bus
   input wire logic                    hsel,
   input wire logic [1:0]              htrans,
   input wire logic                    hwrite,
   input wire logic [ADDR_W-1:0]       haddr,
   input wire logic                    hready,
   input wire logic                    hreadyout,
   input wire logic                    hresp,
   input wire logic [DATA_W-1:0]       hrdata,
   // Events and levels
   input wire logic [CNT_W-1:0]        cnt_value,
   input wire logic                    cnt_wrap,
   input wire logic                    pwm_sync,
   input wire logic [NUM_CH-1:0]       chan_gen,
   input wire logic [NUM_CH-1:0]       chan_out,
   input wire logic [CNT_W-1:0]        period_limit,
   input wire logic [CNT_W-1:0]        counter_start_value,
   input wire logic [NUM_CH-1:0][CNT_W-1:0] cmp_active,
   input wire logic                    load_done
);
   logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
   logic [2:0]        quiet_q, quiet_d;
   logic              rd_pend_q, rd_pend_d, wr_q, wr_d, take, hit;
   // ==========================================
   // Read tracking and quiet-cycle counter
   always_comb begin
      take = hsel && hready && htrans[1];
      hit = 1'b0;
      for (int j = 0; j < NUM_CH; j++) begin
         hit = hit || (cnt_value == cmp_active[j]);
      end
      rd_pend_d = take ? !hwrite : (hreadyout ? 1'b0 : rd_pend_q);
      rd_addr_d = take ? haddr : rd_addr_q;
      wr_d = take && hwrite;
      quiet_d = (wr_q || pwm_sync) ? 3'h0 : ((quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1);
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_addr_q <= 8'h00;
         quiet_q <= 3'h0;
         rd_pend_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         rd_addr_q <= rd_addr_d;
         quiet_q <= quiet_d;
         rd_pend_q <= rd_pend_d;
         wr_q <= wr_d;
      end
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_cause;
      $past(cnt_wrap || hit) || $past(cnt_wrap || hit, 2);
   endsequence
   AST_PERIOD_LOAD: assert property ($changed(period_limit) |-> ##[0:1] load_done)
      else $error("period changed without load");
   AST_START_LOAD: assert property ($changed(counter_start_value) |-> ##[0:1] load_done)
      else $error("start value changed without load");
   AST_CMP_LOAD: assert property ($changed(cmp_active) |-> ##[0:1] load_done)
      else $error("compare changed without load");
   AST_LOAD_CAUSE: assert property (load_done |-> s_cause)
      else $error("load without wrap or match");
   AST_RSV_READ: assert property (rd_pend_q && hreadyout && rd_addr_q == OFF_LOAD
      |-> hrdata[31:10] == 22'h0 && !hrdata[8])
      else $error("reserved load bits not zero");
   AST_UNMAPPED_READ: assert property (rd_pend_q && hreadyout && rd_addr_q > OFF_OVR_ACT
      |-> hrdata == RST_WORD)
      else $error("unmapped read not zero");
   AST_CHAN_STABLE: assert property (quiet_q >= 3'h4 && $past(chan_gen) == $past(chan_gen, 2)
      |-> $stable(chan_out))
      else $error("channel output moved without cause");
   AST_RD_WAIT: assert property (!hreadyout |=> hreadyout)
      else $error("wait state longer than one cycle");
   AST_RESP_OKAY: assert property (hresp == HRESP_OKAY)
      else $error("response not okay");
endmodule

// ### tb/tb_top.sv
// Self-checking testbench for the override and buffered load block
`timescale 1ns/1ps
module tb_top
   import pwmol_pkg::*;
;
   logic                          hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic                          pwm_sync = 1'b0, run = 1'b0, hreadyout, hresp, cnt_wrap, load_done;
   logic [1:0]                    htrans = 2'h0;
   logic [7:0]                    haddr = 8'h00, chan_gen = 8'h00, chan_out;
   logic [31:0]                   hwdata = 32'h0, hrdata;
   logic [15:0]                   cnt_value, period_limit, counter_start_value;
   logic [NUM_CH-1:0][CNT_W-1:0]  cmp_active;
   int                            err_count = 0, comparisons = 0;
   always #2.5 hclk = ~hclk;
   pwmol_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .haddr(haddr), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .cnt_value(cnt_value), .cnt_wrap(cnt_wrap), .pwm_sync(pwm_sync),
      .chan_gen(chan_gen), .chan_out(chan_out), .period_limit(period_limit),
      .counter_start_value(counter_start_value), .cmp_active(cmp_active), .load_done(load_done));
   pwmol_cnt_model u_cnt (.hclk(hclk), .hresetn(hresetn), .run(run), .period_limit(period_limit),
      .counter_start_value(counter_start_value), .cnt_value(cnt_value), .cnt_wrap(cnt_wrap));
   // ==========================================
   // Bus, compare and wait helpers
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(n, q, e);
   endtask
   task automatic wait_ld;
      for (int i = 0; i < 60 && load_done !== 1'b1; i++) @(posedge hclk);
      chk("load_done", {31'h0, load_done}, 32'h1);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_override;
      rd(OFF_LOAD, RST_WORD, "load reset");
      rd(OFF_OVR, RST_WORD, "override reset");
      @(posedge hclk) chan_gen <= 8'h3C;
      wr(OFF_OVR, 32'h0000_050F);
      repeat (3) @(posedge hclk);
      chk("chan_out forced", {24'h0, chan_out}, 32'h35);
      @(posedge hclk) chan_gen <= 8'hC3;
      repeat (3) @(posedge hclk);
      chk("chan_out pass", {24'h0, chan_out}, 32'hC5);
   endtask
   task automatic t_sync;
      wr(OFF_SYNC, 32'h0000_0020);
      wr(OFF_OVR, 32'h0000_FFF0);
      repeat (4) @(posedge hclk);
      chk("chan_out held", {24'h0, chan_out}, 32'hC5);
      rd(OFF_OVR_ACT, 32'h0000_050F, "active override");
      rd(OFF_OVR, 32'h0000_FFF0, "override buffer");
      @(posedge hclk) pwm_sync <= 1'b1;
      @(posedge hclk) pwm_sync <= 1'b0;
      repeat (3) @(posedge hclk);
      chk("chan_out synced", {24'h0, chan_out}, 32'hF3);
   endtask
   task automatic t_load;
      wr(OFF_PERIOD, 32'h0000_0010);
      wr(OFF_START, 32'h0000_0002);
      wr(OFF_CMP0, 32'h0000_0005);
      wr(OFF_CMP0 + 8'h03 * CMP_STRIDE, 32'h0000_0009);
      @(posedge hclk) run <= 1'b1;
      repeat (20) @(posedge hclk);
      chk("period no load", {16'h0, period_limit}, 32'h0);
      wr(OFF_LOAD, 32'h0000_0200);
      wait_ld;
      chk("period", {16'h0, period_limit}, 32'h10);
      chk("start", {16'h0, counter_start_value}, 32'h2);
      chk("cmp0", {16'h0, cmp_active[0]}, 32'h5);
      chk("cmp3", {16'h0, cmp_active[3]}, 32'h9);
   endtask
   task automatic t_match;
      for (int i = 0; i < 60 && cnt_value !== 16'h0003; i++) @(posedge hclk);
      chk("count before stop", {16'h0, cnt_value}, 32'h3);
      run <= 1'b0;
      wr(OFF_LOAD, 32'h0000_0208);
      wr(OFF_PERIOD, 32'h0000_0020);
      @(posedge hclk) run <= 1'b1;
      @(posedge hclk);
      wait_ld;
      chk("count at match load", {16'h0, cnt_value}, 32'hA);
      chk("period match", {16'h0, period_limit}, 32'h20);
   endtask
   task automatic t_regs;
      rd(OFF_LOAD, 32'h0000_0208, "load readback");
      wr(OFF_LOAD, 32'hFFFF_FFFF);
      rd(OFF_LOAD, 32'h0000_02FF, "load reserved");
      rd(8'hFC, RST_WORD, "unmapped");
   endtask
   task automatic results;
      $display("err_count %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ==========================================
   // Main sequence and watchdog
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_override;
      t_sync;
      t_load;
      t_match;
      t_regs;
      results;
   end
   initial begin
      #50000;
      err_count++;
      results;
   end
endmodule
bind pwmol_top pwmol_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .haddr, .hready, .hreadyout,
   .hresp, .hrdata, .cnt_value, .cnt_wrap, .pwm_sync, .chan_gen, .chan_out, .period_limit,
   .counter_start_value, .cmp_active, .load_done);
